//--- design/tmsc_status_config.sv
// Status, configuration and resolution logic of the two-channel temperature monitor
`timescale 1ns/1ps
`default_nettype none
module tmsc_status_config #(
	parameter int CONV_BASE_CYC = tmsc_pkg::CONV_BASE_CYC,
	parameter int REMOTE_CONV_CYC = tmsc_pkg::REMOTE_CONV_CYC,
	parameter int IDLE_CYC = tmsc_pkg::IDLE_CYC
) (
	input wire logic ref_clk, // Core clock
	input wire logic resetn, // Synchronous reset, active low
	input wire logic link_clk, // Bus engine clock
	input wire logic link_req, // Access request pulse
	input wire tmsc_pkg::tmsc_req_t link_cmd, // Access fields
	output logic link_busy, // Access in flight
	output logic link_done, // Access finished pulse
	output logic [7:0] link_rdata, // Read answer
	input wire tmsc_pkg::tmsc_adc_t adc, // Converter results
	input wire tmsc_pkg::tmsc_limits_t limits, // Limit values
	output logic conv_local, // Local conversion running
	output logic conv_remote, // Remote conversion running
	output logic extended_range, // Extended format selected
	output logic [1:0] local_res, // Local resolution code
	output logic alert_o, // Alert pin level when driven
	output logic alert_oe, // Alert pin pulled low
	output logic overheat_o, // Overheat pin level when driven
	output logic overheat_oe // Overheat pin pulled low
);
	// Whole block state
	typedef struct packed {
		tmsc_pkg::tmsc_conv_t conv;
		logic [31:0] cnt;
		logic single;
		logic oneshot_pend;
		logic [7:0] cfg;
		logic [1:0] res;
		logic [7:0] status;
		logic [7:0] cond;
		logic [2:0] consec;
		logic alert_state;
		logic alert_pin;
		logic heat_pin;
		logic od_level;
		logic ph_local;
		logic ph_remote;
	} tmsc_state_t;
	tmsc_state_t s; // Registered state
	tmsc_state_t next_s; // Next state
	logic acc_valid; // Access pulse
	tmsc_pkg::tmsc_req_t acc_cmd; // Access fields
	logic [7:0] acc_rdata; // Read data
	logic wr; // Register write
	logic rd; // Register read
	logic ara; // Alert response seen
	logic rd_status; // Status byte read
	logic l_end; // Local conversion ends
	logic r_end; // Remote conversion ends
	logic rise; // Alert group flag rises

	// Comparator with hysteresis; limit less hysteresis floors at zero
	function automatic logic hyst_cmp(input logic prev, input logic [7:0] t,
		input logic [7:0] lim, input logic [7:0] hy);
		logic [8:0] rel;
		rel = {1'b0, lim} - {1'b0, hy};
		if (rel[8])
		begin
			rel = 9'h000;
		end
		hyst_cmp = prev ? ({1'b0, t} > rel) : (t > lim);
	endfunction

	// Consecutive out-of-limit counter, saturating
	function automatic logic [2:0] bump(input logic [2:0] c, input logic hit);
		if (!hit)
		begin
			bump = 3'h0;
		end
		else if (c == 3'h7)
		begin
			bump = c;
		end
		else
		begin
			bump = c + 3'h1;
		end
	endfunction

	// Local conversion length less one, doubled per resolution step
	function automatic logic [31:0] loc_cyc(input logic [1:0] code);
		loc_cyc = (32'(CONV_BASE_CYC) << code) - 32'h1;
	endfunction

	// Bus engine front end in its own clock domain
	tmsc_link_port u_link (
		.link_clk(link_clk),
		.ref_clk(ref_clk),
		.resetn(resetn),
		.link_req(link_req),
		.link_cmd(link_cmd),
		.link_busy(link_busy),
		.link_done(link_done),
		.link_rdata(link_rdata),
		.acc_valid(acc_valid),
		.acc_cmd(acc_cmd),
		.acc_rdata(acc_rdata)
	);

	// Access kind decode
	assign wr = acc_valid && acc_cmd.write && !acc_cmd.ara;
	assign rd = acc_valid && !acc_cmd.write && !acc_cmd.ara;
	assign ara = acc_valid && acc_cmd.ara;
	assign rd_status = rd && (acc_cmd.ptr == tmsc_pkg::PTR_STATUS);

	// Next state: sequencer, flags, registers, pins
	always_comb
	begin
		next_s = s;
		l_end = 1'b0;
		r_end = 1'b0;
		rise = 1'b0;
		acc_rdata = 8'h00;
		next_s.od_level = 1'b0;
		// Conversion sequencer
		case (s.conv)
			tmsc_pkg::CV_IDLE:
			begin
				// Run continuously, or once on a one-shot
				if (!s.cfg[tmsc_pkg::CFG_SD] || s.oneshot_pend)
				begin
					next_s.conv = tmsc_pkg::CV_LOCAL;
					next_s.cnt = loc_cyc(s.res);
					next_s.single = s.cfg[tmsc_pkg::CFG_SD];
					next_s.oneshot_pend = 1'b0;
				end
			end
			tmsc_pkg::CV_LOCAL:
			begin
				// Shutdown stops at once
				if (s.cfg[tmsc_pkg::CFG_SD] && !s.single)
				begin
					next_s.conv = tmsc_pkg::CV_IDLE;
				end
				else if (s.cnt == 32'h0)
				begin
					l_end = 1'b1;
					next_s.conv = tmsc_pkg::CV_REMOTE;
					next_s.cnt = 32'(REMOTE_CONV_CYC) - 32'h1;
				end
				else
				begin
					next_s.cnt = s.cnt - 32'h1;
				end
			end
			tmsc_pkg::CV_REMOTE:
			begin
				if (s.cfg[tmsc_pkg::CFG_SD] && !s.single)
				begin
					next_s.conv = tmsc_pkg::CV_IDLE;
				end
				else if (s.cnt == 32'h0)
				begin
					// One-shot returns to shutdown here
					r_end = 1'b1;
					next_s.conv = s.single ? tmsc_pkg::CV_IDLE : tmsc_pkg::CV_WAIT;
					next_s.single = 1'b0;
					next_s.cnt = 32'(IDLE_CYC) - 32'h1;
				end
				else
				begin
					next_s.cnt = s.cnt - 32'h1;
				end
			end
			tmsc_pkg::CV_WAIT:
			begin
				// Idle gap between conversion cycles
				if (s.cfg[tmsc_pkg::CFG_SD])
				begin
					next_s.conv = tmsc_pkg::CV_IDLE;
				end
				else if (s.cnt == 32'h0)
				begin
					next_s.conv = tmsc_pkg::CV_LOCAL;
					next_s.cnt = loc_cyc(s.res);
				end
				else
				begin
					next_s.cnt = s.cnt - 32'h1;
				end
			end
			default:
			begin
				next_s.conv = tmsc_pkg::CV_IDLE;
			end
		endcase
		// Status read clears latched flags whose cause is gone
		if (rd_status)
		begin
			next_s.status = s.status & ~((tmsc_pkg::LATCH_ALWAYS |
				(s.cfg[tmsc_pkg::CFG_MODE] ? 8'h00 : tmsc_pkg::LATCH_HIGH)) & ~s.cond);
		end
		// Local results; sets come after the clear so they win
		if (l_end)
		begin
			next_s.cond[tmsc_pkg::ST_LUP] = adc.local_temp > limits.local_high;
			next_s.cond[tmsc_pkg::ST_LLO] = adc.local_temp < limits.local_low;
			next_s.status[tmsc_pkg::ST_LHEAT] = hyst_cmp(s.status[tmsc_pkg::ST_LHEAT],
				adc.local_temp, limits.local_heat, limits.hyst);
			if (s.cfg[tmsc_pkg::CFG_MODE])
			begin
				next_s.status[tmsc_pkg::ST_LUP] = hyst_cmp(s.status[tmsc_pkg::ST_LUP],
					adc.local_temp, limits.local_high, limits.hyst);
			end
			else if (next_s.cond[tmsc_pkg::ST_LUP])
			begin
				next_s.status[tmsc_pkg::ST_LUP] = 1'b1;
			end
			if (next_s.cond[tmsc_pkg::ST_LLO])
			begin
				next_s.status[tmsc_pkg::ST_LLO] = 1'b1;
			end
			next_s.consec = bump(s.consec, next_s.cond[tmsc_pkg::ST_LUP] |
				next_s.cond[tmsc_pkg::ST_LLO]);
		end
		// Remote results, open diode checked only here
		if (r_end)
		begin
			next_s.cond[tmsc_pkg::ST_RUP] = adc.remote_temp > limits.remote_high;
			next_s.cond[tmsc_pkg::ST_RLO] = adc.remote_temp < limits.remote_low;
			next_s.cond[tmsc_pkg::ST_OPEN] = adc.diode_open;
			next_s.status[tmsc_pkg::ST_RHEAT] = hyst_cmp(s.status[tmsc_pkg::ST_RHEAT],
				adc.remote_temp, limits.remote_heat, limits.hyst);
			if (s.cfg[tmsc_pkg::CFG_MODE])
			begin
				next_s.status[tmsc_pkg::ST_RUP] = hyst_cmp(s.status[tmsc_pkg::ST_RUP],
					adc.remote_temp, limits.remote_high, limits.hyst);
			end
			else if (next_s.cond[tmsc_pkg::ST_RUP])
			begin
				next_s.status[tmsc_pkg::ST_RUP] = 1'b1;
			end
			if (next_s.cond[tmsc_pkg::ST_RLO])
			begin
				next_s.status[tmsc_pkg::ST_RLO] = 1'b1;
			end
			if (adc.diode_open)
			begin
				next_s.status[tmsc_pkg::ST_OPEN] = 1'b1;
			end
			next_s.consec = bump(s.consec, next_s.cond[tmsc_pkg::ST_RUP] |
				next_s.cond[tmsc_pkg::ST_RLO] | adc.diode_open);
		end
		// Busy follows the sequencer
		next_s.status[tmsc_pkg::ST_BUSY] = (next_s.conv == tmsc_pkg::CV_LOCAL) ||
			(next_s.conv == tmsc_pkg::CV_REMOTE);
		next_s.ph_local = next_s.conv == tmsc_pkg::CV_LOCAL;
		next_s.ph_remote = next_s.conv == tmsc_pkg::CV_REMOTE;
		// Register writes; status pointer has no write path
		if (wr)
		begin
			case (acc_cmd.ptr)
				tmsc_pkg::PTR_CFG_WR:
				begin
					next_s.cfg = acc_cmd.wdata & tmsc_pkg::CFG_IMPL;
				end
				tmsc_pkg::PTR_PREC:
				begin
					next_s.res = acc_cmd.wdata[1:0];
				end
				tmsc_pkg::PTR_ONESHOT:
				begin
					// Only honoured in shutdown with nothing running
					if (s.cfg[tmsc_pkg::CFG_SD] && (s.conv == tmsc_pkg::CV_IDLE))
					begin
						next_s.oneshot_pend = 1'b1;
					end
				end
				default:
				begin
					next_s.oneshot_pend = s.oneshot_pend;
				end
			endcase
		end
		// Read data
		case (acc_cmd.ptr)
			tmsc_pkg::PTR_STATUS:
			begin
				acc_rdata = s.status;
			end
			tmsc_pkg::PTR_CFG_RD:
			begin
				acc_rdata = s.cfg;
			end
			tmsc_pkg::PTR_PREC:
			begin
				acc_rdata = tmsc_pkg::PREC_FIXED | {6'h00, s.res};
			end
			default:
			begin
				acc_rdata = 8'h00;
			end
		endcase
		// Alert state: response releases, a new flag rise wins
		if (ara)
		begin
			next_s.alert_state = 1'b0;
		end
		rise = |(next_s.status & ~s.status & tmsc_pkg::ALERT_GROUP);
		if (!s.cfg[tmsc_pkg::CFG_MODE] && rise &&
			(next_s.consec >= tmsc_pkg::FAULT_COUNT))
		begin
			next_s.alert_state = 1'b1;
		end
		// Shared pin: masked alert or second overheat output
		if (next_s.cfg[tmsc_pkg::CFG_MODE])
		begin
			next_s.alert_pin = next_s.status[tmsc_pkg::ST_LUP] |
				next_s.status[tmsc_pkg::ST_RUP];
		end
		else
		begin
			next_s.alert_pin = next_s.alert_state & ~next_s.cfg[tmsc_pkg::CFG_MASK];
		end
		next_s.heat_pin = next_s.status[tmsc_pkg::ST_LHEAT] | next_s.status[tmsc_pkg::ST_RHEAT];
	end

	// State register with synchronous reset
	always_ff @(posedge ref_clk)
	begin
		if (!resetn)
		begin
			s <= '0;
			s.conv <= tmsc_pkg::CV_IDLE;
			s.cfg <= tmsc_pkg::CFG_RESET;
			s.res <= tmsc_pkg::PREC_RESET[1:0];
		end
		else
		begin
			s <= next_s;
		end
	end

	// Outputs straight from the state register
	assign conv_local = s.ph_local;
	assign conv_remote = s.ph_remote;
	assign extended_range = s.cfg[tmsc_pkg::CFG_RANGE];
	assign local_res = s.res;
	assign alert_o = s.od_level;
	assign alert_oe = s.alert_pin;
	assign overheat_o = s.od_level;
	assign overheat_oe = s.heat_pin;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!resetn);

	// Reset release, sampled as a rise of resetn
	sequence seq_release;
		$rose(resetn);
	endsequence
	// One-shot accepted in shutdown
	sequence seq_oneshot;
		wr && acc_cmd.ptr == tmsc_pkg::PTR_ONESHOT && s.cfg[tmsc_pkg::CFG_SD] &&
			s.conv == tmsc_pkg::CV_IDLE;
	endsequence

	chk_busy_power_up: assert property (
		seq_release |-> ##[1:2] s.status[tmsc_pkg::ST_BUSY])
		else $error("busy not raised after reset");
	chk_status_no_write: assert property (
		wr && acc_cmd.ptr == tmsc_pkg::PTR_STATUS && !l_end && !r_end |=> $stable(s.status[6:0]))
		else $error("status changed by a write");
	chk_open_latch: assert property (
		r_end && adc.diode_open |=> s.status[tmsc_pkg::ST_OPEN])
		else $error("open diode not latched");
	chk_remote_heat_set: assert property (
		r_end && adc.remote_temp > limits.remote_heat |=> s.status[tmsc_pkg::ST_RHEAT])
		else $error("remote overheat flag not set");
	chk_local_low_latch: assert property (
		l_end && adc.local_temp < limits.local_low |=> s.status[tmsc_pkg::ST_LLO])
		else $error("local low flag not set");
	chk_read_keeps_cause: assert property (
		rd_status && s.status[tmsc_pkg::ST_LLO] && s.cond[tmsc_pkg::ST_LLO]
			|=> s.status[tmsc_pkg::ST_LLO])
		else $error("latched flag cleared while cause stands");
	chk_read_live_kept: assert property (
		rd_status && !l_end && !r_end |=> $stable(s.status[1:0]))
		else $error("live flag changed by status read");
	chk_read_keeps_alert: assert property (
		rd_status && alert_oe && !s.cfg[tmsc_pkg::CFG_MODE] |=> alert_oe)
		else $error("status read released alert");
	chk_response_release: assert property (
		ara && !s.cfg[tmsc_pkg::CFG_MODE] && !l_end && !r_end |=> !alert_oe)
		else $error("alert response did not release alert");
	chk_rise_alerts: assert property (
		!s.cfg[tmsc_pkg::CFG_MODE] && !s.cfg[tmsc_pkg::CFG_MASK] && !wr && l_end &&
			adc.local_temp < limits.local_low && !s.status[tmsc_pkg::ST_LLO] |=> alert_oe)
		else $error("flag rise did not pull alert low");
	chk_mask_blocks: assert property (
		(!s.cfg[tmsc_pkg::CFG_MODE] && s.cfg[tmsc_pkg::CFG_MASK] && !wr) [*2] |-> !alert_oe)
		else $error("masked alert pin driven");
	chk_shutdown_stops: assert property (
		s.cfg[tmsc_pkg::CFG_SD] && !s.single && !s.oneshot_pend |=> !s.status[tmsc_pkg::ST_BUSY])
		else $error("conversion kept running in shutdown");
	chk_second_overheat_output_pin: assert property (
		s.cfg[tmsc_pkg::CFG_MODE] && !wr && !l_end && !r_end
			|=> alert_oe == ($past(s.status[tmsc_pkg::ST_LUP]) | $past(s.status[tmsc_pkg::ST_RUP])))
		else $error("second overheat output wrong");
	chk_config_readback: assert property (
		wr && acc_cmd.ptr == tmsc_pkg::PTR_CFG_WR
			|=> s.cfg == ($past(acc_cmd.wdata) & tmsc_pkg::CFG_IMPL))
		else $error("configuration not stored");
	chk_local_length: assert property (
		$rose(s.ph_local) && $stable(s.res) |-> s.cnt == loc_cyc(s.res))
		else $error("local conversion length wrong");
	chk_oneshot_start: assert property (
		seq_oneshot |-> ##[1:3] s.status[tmsc_pkg::ST_BUSY])
		else $error("one-shot did not start a conversion");
endmodule
`default_nettype wire

//--- shared/tmsc_pkg.sv
// Constants, carriers and notes for the temperature monitor status logic
package tmsc_pkg;
	// Register pointers
	localparam logic [7:0] PTR_STATUS = 8'h02;
	localparam logic [7:0] PTR_CFG_RD = 8'h03;
	localparam logic [7:0] PTR_CFG_WR = 8'h09;
	localparam logic [7:0] PTR_ONESHOT = 8'h0F;
	localparam logic [7:0] PTR_PREC = 8'h1A;
	// Reset values and field layouts
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [7:0] CFG_IMPL = 8'hE4;
	localparam logic [7:0] PREC_RESET = 8'h1C;
	localparam logic [7:0] PREC_FIXED = 8'h1C;
	localparam int CFG_MASK = 7;
	localparam int CFG_SD = 6;
	localparam int CFG_MODE = 5;
	localparam int CFG_RANGE = 2;
	// Status bit positions
	localparam int ST_BUSY = 7;
	localparam int ST_LUP = 6;
	localparam int ST_LLO = 5;
	localparam int ST_RUP = 4;
	localparam int ST_RLO = 3;
	localparam int ST_OPEN = 2;
	localparam int ST_RHEAT = 1;
	localparam int ST_LHEAT = 0;
	localparam logic [7:0] ALERT_GROUP = 8'h7C;
	localparam logic [7:0] LATCH_ALWAYS = 8'h2C;
	localparam logic [7:0] LATCH_HIGH = 8'h50;
	localparam logic [2:0] FAULT_COUNT = 3'h1;
	// Timing: figures in microseconds, counts at the core clock
	localparam int CLK_PERIOD_NS = 10;
	localparam int CONV_BASE_US = 12500;
	localparam int REMOTE_CONV_US = 100000;
	localparam int IDLE_US = 1000;
	localparam int CONV_BASE_CYC = CONV_BASE_US * 1000 / CLK_PERIOD_NS;
	localparam int REMOTE_CONV_CYC = REMOTE_CONV_US * 1000 / CLK_PERIOD_NS;
	localparam int IDLE_CYC = IDLE_US * 1000 / CLK_PERIOD_NS;
	// One register access from the bus engine
	typedef struct packed {
		logic write;
		logic ara;
		logic [7:0] ptr;
		logic [7:0] wdata;
	} tmsc_req_t;
	// Converter results
	typedef struct packed {
		logic [7:0] local_temp;
		logic [7:0] remote_temp;
		logic diode_open;
	} tmsc_adc_t;
	// Limit register contents
	typedef struct packed {
		logic [7:0] local_high;
		logic [7:0] local_low;
		logic [7:0] remote_high;
		logic [7:0] remote_low;
		logic [7:0] local_heat;
		logic [7:0] remote_heat;
		logic [7:0] hyst;
	} tmsc_limits_t;
	// Conversion sequencer states
	typedef enum logic [3:0] {
		CV_IDLE = 4'h1,
		CV_LOCAL = 4'h2,
		CV_REMOTE = 4'h4,
		CV_WAIT = 4'h8
	} tmsc_conv_t;
endpackage

//--- design/tmsc_link_port.sv
// Handshake crossing between the bus engine clock and the core clock
`timescale 1ns/1ps
`default_nettype none
module tmsc_link_port (
	input wire logic link_clk, // Bus engine clock
	input wire logic ref_clk, // Core clock
	input wire logic resetn, // Core reset, active low
	input wire logic link_req, // Access request pulse
	input wire tmsc_pkg::tmsc_req_t link_cmd, // Access fields
	output logic link_busy, // Access in flight
	output logic link_done, // Access finished pulse
	output logic [7:0] link_rdata, // Read answer
	output logic acc_valid, // Access pulse in core domain
	output tmsc_pkg::tmsc_req_t acc_cmd, // Held access fields
	input wire logic [7:0] acc_rdata // Read data from core
);
	// Link side state
	typedef struct packed {
		logic rst_s1;
		logic rst_s2;
		logic ack_s1;
		logic ack_s2;
		logic ack_s3;
		logic tgl;
		logic busy;
		logic done;
		logic [7:0] rdata;
		tmsc_pkg::tmsc_req_t hold;
	} tmsc_lside_t;
	// Core side state
	typedef struct packed {
		logic req_s1;
		logic req_s2;
		logic req_s3;
		logic valid;
		logic ack_tgl;
		logic [7:0] rdata;
	} tmsc_rside_t;
	tmsc_lside_t l; // Link registers
	tmsc_lside_t next_l; // Link next state
	tmsc_rside_t r; // Core registers
	tmsc_rside_t next_r; // Core next state
	// Link side: take request, wait for acknowledge toggle
	always_comb
	begin
		next_l = l;
		next_l.rst_s1 = resetn;
		next_l.rst_s2 = l.rst_s1;
		next_l.ack_s1 = r.ack_tgl;
		next_l.ack_s2 = l.ack_s1;
		next_l.ack_s3 = l.ack_s2;
		next_l.done = 1'b0;
		// Answer returned
		if (l.ack_s2 != l.ack_s3)
		begin
			next_l.rdata = r.rdata;
			next_l.done = 1'b1;
			next_l.busy = 1'b0;
		end
		// New request only when idle
		if (link_req && !l.busy)
		begin
			next_l.hold = link_cmd;
			next_l.tgl = ~l.tgl;
			next_l.busy = 1'b1;
		end
		// Reset, carried over by the synchroniser
		if (!l.rst_s2)
		begin
			next_l.tgl = 1'b0;
			next_l.busy = 1'b0;
			next_l.done = 1'b0;
			next_l.rdata = 8'h00;
			next_l.hold = '0;
		end
	end
	// Link side registers
	always_ff @(posedge link_clk)
	begin
		l <= next_l;
	end
	// Core side: detect toggle, pulse access, capture answer
	always_comb
	begin
		next_r = r;
		next_r.req_s1 = l.tgl;
		next_r.req_s2 = r.req_s1;
		next_r.req_s3 = r.req_s2;
		next_r.valid = r.req_s2 ^ r.req_s3;
		// Access served this cycle
		if (r.valid)
		begin
			next_r.rdata = acc_rdata;
			next_r.ack_tgl = ~r.ack_tgl;
		end
		if (!resetn)
		begin
			next_r = '0;
		end
	end
	// Core side registers
	always_ff @(posedge ref_clk)
	begin
		r <= next_r;
	end
	assign link_busy = l.busy;
	assign link_done = l.done;
	assign link_rdata = l.rdata;
	assign acc_valid = r.valid;
	assign acc_cmd = l.hold;
endmodule
`default_nettype wire

//--- test/tmsc_host_model.sv
// Host controller model issuing single register accesses over the link
`timescale 1ns/1ps
`default_nettype none
module tmsc_host_model (
	input wire logic link_clk, // Link clock
	output logic link_req, // Access request
	output tmsc_pkg::tmsc_req_t link_cmd, // Access fields
	input wire logic link_busy, // Device busy
	input wire logic link_done, // Access finished
	input wire logic [7:0] link_rdata // Read answer
);
	initial
	begin
		link_req = 1'b0;
		link_cmd = '0;
	end
	// One access: raise at a falling edge, hold until done is seen, bounded wait
	task automatic access(input logic wr, input logic ara, input logic [7:0] ptr,
		input logic [7:0] wd, output logic [7:0] rd, output logic ok);
		ok = 1'b0;
		rd = 8'h00;
		// Reserved config bits go out as zero
		if (wr && ptr == tmsc_pkg::PTR_CFG_WR)
			wd = wd & tmsc_pkg::CFG_IMPL;
		// Filler bits of the resolution byte go out fixed
		if (wr && ptr == tmsc_pkg::PTR_PREC)
			wd = (wd & 8'h03) | tmsc_pkg::PREC_FIXED;
		@(negedge link_clk);
		link_req = 1'b1;
		link_cmd = '{write: wr, ara: ara, ptr: ptr, wdata: wd};
		// Request and fields stand until the done pulse is seen
		for (int n = 0; n < 16 && !ok; n++)
		begin
			@(negedge link_clk);
			if (link_done === 1'b1)
			begin
				ok = 1'b1;
				rd = link_rdata;
			end
		end
		// Dropped before the next rising edge, so no second take
		link_req = 1'b0;
		// Released fields do not keep their value
		link_cmd = ~link_cmd;
	endtask
endmodule
`default_nettype wire

//--- test/testbench.sv
// Self-checking bench for the status, configuration and resolution logic
`timescale 1ns/1ps
`default_nettype none
module testbench;
	typedef struct packed {
		logic wr;
		logic [7:0] ptr;
		logic [7:0] wd;
		logic [7:0] exp;
		logic [7:0] msk;
	} tmsc_row_t;
	logic ref_clk = 1'b0; // Core clock
	logic link_clk = 1'b0; // Link clock
	logic resetn = 1'b0; // Reset, active low
	logic link_req, link_busy, link_done; // Link handshake
	tmsc_pkg::tmsc_req_t link_cmd; // Access fields
	logic [7:0] link_rdata, rd; // Read answers
	tmsc_pkg::tmsc_adc_t adc = '{8'h20, 8'h20, 1'b0}; // Converter results
	tmsc_pkg::tmsc_limits_t limits = '{8'h50, 8'h10, 8'h50, 8'h10, 8'h70, 8'h70, 8'h0A};
	logic conv_local, conv_remote, extended_range, alert_o, alert_oe, overheat_o, overheat_oe;
	logic [1:0] local_res; // Resolution code
	int mismatches = 0; // Failed compares
	int samples_checked = 0; // Compares made
	// Register access rows: write flag, pointer, data, expected read, compare mask
	tmsc_row_t rows [13] = '{
		'{1'b0, 8'h03, 8'h00, 8'h00, 8'hFF},
		'{1'b0, 8'h1A, 8'h00, 8'h1C, 8'hFF},
		'{1'b0, 8'h02, 8'h00, 8'h00, 8'h7F},
		'{1'b1, 8'h09, 8'h04, 8'h00, 8'h00},
		'{1'b0, 8'h03, 8'h00, 8'h04, 8'hFF},
		'{1'b1, 8'h03, 8'hFF, 8'h00, 8'h00},
		'{1'b0, 8'h03, 8'h00, 8'h04, 8'hFF},
		'{1'b1, 8'h02, 8'hFF, 8'h00, 8'h00},
		'{1'b0, 8'h02, 8'h00, 8'h00, 8'h7F},
		'{1'b1, 8'h1A, 8'h1F, 8'h00, 8'h00},
		'{1'b0, 8'h1A, 8'h00, 8'h1F, 8'hFF},
		'{1'b1, 8'h1A, 8'h1D, 8'h00, 8'h00},
		'{1'b0, 8'h1A, 8'h00, 8'h1D, 8'hFF}
	};
	always #5 ref_clk = ~ref_clk;
	initial
	begin
		#3;
		forever #32 link_clk = ~link_clk;
	end
	tmsc_status_config #(.CONV_BASE_CYC(20), .REMOTE_CONV_CYC(40), .IDLE_CYC(10)) dut (
		.ref_clk(ref_clk), .resetn(resetn), .link_clk(link_clk), .link_req(link_req),
		.link_cmd(link_cmd), .link_busy(link_busy), .link_done(link_done),
		.link_rdata(link_rdata), .adc(adc), .limits(limits), .conv_local(conv_local),
		.conv_remote(conv_remote), .extended_range(extended_range), .local_res(local_res),
		.alert_o(alert_o), .alert_oe(alert_oe), .overheat_o(overheat_o),
		.overheat_oe(overheat_oe));
	tmsc_host_model host (.link_clk(link_clk), .link_req(link_req), .link_cmd(link_cmd),
		.link_busy(link_busy), .link_done(link_done), .link_rdata(link_rdata));
	// Verdict and end of run
	task automatic wrap_up;
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Compare one value
	task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask
	// One link access, a lost answer ends the run
	task automatic bus(input logic wr, input logic ara, input logic [7:0] ptr, input logic [7:0] wd);
		logic ok;
		host.access(wr, ara, ptr, wd, rd, ok);
		if (ok !== 1'b1)
		begin
			mismatches++;
			$display("Error link_done expected 1 seen 0");
			wrap_up;
		end
	endtask
	// Two full conversion rounds at the shortened counts
	task automatic wait_conv;
		repeat (200) @(negedge ref_clk);
	endtask
	// Main sequence
	initial
	begin
		repeat (40) @(negedge ref_clk);
		check("reset pins", 8'h00, {alert_o, alert_oe, overheat_o, overheat_oe, conv_local,
			conv_remote, extended_range, link_busy});
		resetn = 1'b1;
		@(negedge ref_clk);
		check("conv_local", 8'h01, {7'h00, conv_local});
		repeat (5) @(posedge link_clk);
		foreach (rows[i])
		begin
			bus(rows[i].wr, 1'b0, rows[i].ptr, rows[i].wd);
			if (!rows[i].wr)
				check("row read", rows[i].exp, rd & rows[i].msk);
		end
		check("range and res", 8'h05, {5'h00, extended_range, local_res});
		// Low limit and open diode latch, alert stays until response
		@(negedge ref_clk);
		adc = '{8'h05, 8'h20, 1'b1};
		wait_conv;
		bus(1'b0, 1'b0, 8'h02, 8'h00);
		check("low open", 8'h24, rd & 8'h24);
		check("alert set", 8'h01, {7'h00, alert_oe});
		@(negedge ref_clk);
		adc = '{8'h20, 8'h20, 1'b0};
		wait_conv;
		bus(1'b0, 1'b0, 8'h02, 8'h00);
		check("latched", 8'h24, rd & 8'h24);
		bus(1'b0, 1'b0, 8'h02, 8'h00);
		check("cleared", 8'h00, rd & 8'h7C);
		check("alert kept", 8'h01, {7'h00, alert_oe});
		bus(1'b0, 1'b1, 8'h00, 8'h00);
		check("alert released", 8'h00, {7'h00, alert_oe});
		// Masked alert keeps its state
		bus(1'b1, 1'b0, 8'h09, 8'h80);
		@(negedge ref_clk);
		adc = '{8'h20, 8'h60, 1'b0};
		wait_conv;
		check("alert masked", 8'h00, {7'h00, alert_oe});
		bus(1'b1, 1'b0, 8'h09, 8'h00);
		check("alert unmasked", 8'h01, {7'h00, alert_oe});
		bus(1'b1, 1'b0, 8'h09, 8'h20);
		// Comparator mode with hysteresis on high and overheat limits
		@(negedge ref_clk);
		adc = '{8'h75, 8'h60, 1'b0};
		wait_conv;
		bus(1'b0, 1'b0, 8'h02, 8'h00);
		check("comparator set", 8'h51, rd & 8'h53);
		check("pins set", 8'h03, {6'h00, alert_oe, overheat_oe});
		@(negedge ref_clk);
		adc = '{8'h68, 8'h4A, 1'b0};
		wait_conv;
		check("pins held", 8'h03, {6'h00, alert_oe, overheat_oe});
		@(negedge ref_clk);
		adc = '{8'h20, 8'h20, 1'b0};
		wait_conv;
		bus(1'b0, 1'b0, 8'h02, 8'h00);
		check("comparator clear", 8'h00, rd & 8'h53);
		check("pins clear", 8'h00, {6'h00, alert_oe, overheat_oe});
		// Shutdown, then a single one-shot round
		bus(1'b1, 1'b0, 8'h09, 8'h40);
		wait_conv;
		check("shut down", 8'h00, {6'h00, conv_local, conv_remote});
		bus(1'b1, 1'b0, 8'h0F, 8'hA5);
		check("one shot", 8'h01, {7'h00, conv_local | conv_remote});
		wait_conv;
		check("back to shutdown", 8'h00, {6'h00, conv_local, conv_remote});
		bus(1'b1, 1'b0, 8'h09, 8'h00);
		wait_conv;
		bus(1'b0, 1'b0, 8'h02, 8'h00);
		check("resumed", 8'h00, rd & 8'h7F);
		// Mid-run reset returns registers and pins to their reset values
		bus(1'b1, 1'b0, 8'h09, 8'h04);
		@(negedge ref_clk);
		resetn = 1'b0;
		repeat (40) @(negedge ref_clk);
		check("mid reset pins", 8'h00, {alert_o, alert_oe, overheat_o, overheat_oe, conv_local,
			conv_remote, extended_range, link_busy});
		resetn = 1'b1;
		@(negedge ref_clk);
		check("busy again", 8'h01, {7'h00, conv_local});
		repeat (5) @(posedge link_clk);
		bus(1'b0, 1'b0, 8'h03, 8'h00);
		check("config reset", 8'h00, rd);
		bus(1'b0, 1'b0, 8'h1A, 8'h00);
		check("res reset", 8'h1C, rd);
		wrap_up;
	end
endmodule
`default_nettype wire
